/* File: sprx_pkg.sv */
/*
 Constants, register map and field layout for the S/PDIF receiver status block.
 Assumes one 10 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package sprx_pkg;
   localparam int         BLK_FRAMES     = 192;
   localparam int         BUF_WORDS      = 24;
   localparam int         NUM_ERR        = 7;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RX_ERR     = 8'h20;
   localparam logic [7:0] IDX_ERR_MASK   = 8'h21;
   localparam logic [7:0] IDX_BUF_CTRL   = 8'h22;
   localparam logic [7:0] IDX_CS_IRQ     = 8'h23;
   localparam logic [7:0] IDX_CS_IRQ_MSK = 8'h24;
   localparam logic [7:0] IDX_DECODED    = 8'h25;
   localparam logic [7:0] IDX_BUF_BASE   = 8'h4A;
   // Buffer control fields
   localparam int         F_CHSEL        = 0;
   localparam int         F_SRCSEL       = 1;
   localparam int         F_WIDTH        = 2;
   localparam int         F_ONEB_SF      = 3;
   localparam int         F_HOLD_LO      = 4;
   localparam int         F_AUTODE       = 6;
   localparam logic [6:0] BUF_CTRL_RST   = 7'h00;
   localparam logic [6:0] ERR_MASK_RST   = 7'h00;
   localparam logic [6:0] SAMPLE_AFFECT  = 7'h1F;
   localparam logic [7:0] CAT_GENERAL    = 8'h00;
   localparam logic [2:0] EMPH_CONS_5015 = 3'h1;
   localparam logic [2:0] EMPH_PRO_5015  = 3'h4;
   // Hold policies
   typedef enum logic [1:0] {
      SPRX_HOLD_REPEAT = 2'h0,
      SPRX_HOLD_ZERO   = 2'h1,
      SPRX_HOLD_PASS   = 2'h3
   } sprx_hold_type;
endpackage

/* File: sprx_status_buffer.sv */
/*
 Receiver error logging with sample hold, channel status decode and
 the two-stage D/E status and user buffers behind an Avalon-MM slave.
 Assumes the frame decoder runs on core_clk and gives one strobe per subframe.
*/
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sprx_status_buffer (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Subframe stream from the decoder
   input  wire logic        sf_valid,
   input  wire logic        sf_is_b,
   input  wire logic        sf_block_start,
   input  wire logic [23:0] sf_sample,
   input  wire logic        sf_cbit,
   input  wire logic        sf_ubit,
   input  wire logic        sf_vbit,
   // Error conditions
   input  wire logic        pll_unlock,
   input  wire logic        eye_margin_warning,
   input  wire logic        biphase_code_error,
   input  wire logic        odd_even_check_error,
   input  wire logic        subcode_q_checksum_error,
   input  wire logic        status_block_checksum_error,
   input  wire logic        nonpcm_sync_seen,
   // Audio out to serial port
   output logic [23:0]      out_sample,
   output logic             out_valid,
   output logic             out_is_b,
   output logic             deemph_enable,
   // Interrupts
   output logic             receiver_error_irq,
   output logic             status_change_irq
);
   logic [6:0]  err_r;
   logic [6:0]  err_mask_r;
   logic [6:0]  buf_ctrl_r;
   logic        cs_irq_r;
   logic        cs_irq_mask_r;
   logic [6:0]  err_in;
   logic [6:0]  err_hit;
   logic [15:0] cs_d [sprx_pkg::BUF_WORDS];
   logic [15:0] cs_e [sprx_pkg::BUF_WORDS];
   logic [15:0] us_d [sprx_pkg::BUF_WORDS];
   logic [15:0] us_e [sprx_pkg::BUF_WORDS];
   logic [7:0]  frame_r;
   logic        xfer_pend_r;
   logic        changed;
   logic [191:0] cs_sel;
   logic [23:0] hold_a_r;
   logic [23:0] hold_b_r;
   logic        sample_err;
   logic        ack_r;
   logic        rd_fire;
   logic        wr_fire;
   logic [7:0]  idx;
   logic [31:0] rd_val;
   logic        studio_format_flag;
   logic        copyright_flag;
   logic        first_generation_flag;
   logic        audio_flag;
   logic        emph_5015;
   logic [3:0]  word_len;
   logic [7:0]  category;
   sprx_pkg::sprx_hold_type hold_sel;

   // Byte lane of bit n: bit 7 is the earliest received
   function automatic logic [2:0] bit_pos(input logic [7:0] n);
      bit_pos = 3'h7 - n[2:0];
   endfunction

   // Categories whose generation bit has inverted sense
   function automatic logic gen_inverted(input logic [7:0] cat);
      gen_inverted = (cat[7:5] == 3'h1) || (cat[7:4] == 4'h7) || (cat[7:5] == 3'h4);
   endfunction

   // Bus handshake: one wait state, then the answer
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign rd_fire         = avs_read & ~avs_waitrequest;
   assign wr_fire         = avs_write & ~avs_waitrequest;
   assign idx             = avs_address[9:2];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   // Error sources; validity taken from the subframe strobe
   assign err_in  = {status_block_checksum_error, subcode_q_checksum_error,
                     odd_even_check_error, biphase_code_error, eye_margin_warning,
                     sf_valid & sf_vbit, pll_unlock};
   assign err_hit = err_in & err_mask_r;

   // Sticky error flags; a new hit wins over the read clear
   // Only bits already reported in the read data are cleared, so a late hit survives
   generate
      for (genvar g = 0; g < sprx_pkg::NUM_ERR; g++) begin : g_err
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               err_r[g] <= 1'b0;
            end else if (err_hit[g]) begin
               err_r[g] <= 1'b1;
            end else if (rd_fire && idx == sprx_pkg::IDX_RX_ERR && avs_readdata[g]) begin
               err_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign receiver_error_irq = |err_r;

   // Software-written control registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         err_mask_r    <= sprx_pkg::ERR_MASK_RST;
         buf_ctrl_r    <= sprx_pkg::BUF_CTRL_RST;
         cs_irq_mask_r <= 1'b0;
      end else if (wr_fire) begin
         if (idx == sprx_pkg::IDX_ERR_MASK) begin
            err_mask_r <= avs_writedata[6:0];
         end
         if (idx == sprx_pkg::IDX_BUF_CTRL) begin
            buf_ctrl_r <= avs_writedata[6:0];
         end
         if (idx == sprx_pkg::IDX_CS_IRQ_MSK) begin
            cs_irq_mask_r <= avs_writedata[0];
         end
      end
   end

   assign hold_sel = sprx_pkg::sprx_hold_type'(buf_ctrl_r[sprx_pkg::F_HOLD_LO +: 2]);

   // Frame position within the block
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_r <= 8'h00;
      end else if (sf_valid && sf_is_b) begin
         if (frame_r == 8'(sprx_pkg::BLK_FRAMES - 1)) begin
            frame_r <= 8'h00;
         end else begin
            frame_r <= frame_r + 8'h01;
         end
      end else if (sf_valid && sf_block_start) begin
         frame_r <= 8'h00;
      end
   end

   // Transfer pending after the last B subframe of a block
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         xfer_pend_r <= 1'b0;
      end else begin
         xfer_pend_r <= sf_valid & sf_is_b & (frame_r == 8'(sprx_pkg::BLK_FRAMES - 1));
      end
   end

   // Incoming status and user bits land in buffer D
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < sprx_pkg::BUF_WORDS; i++) begin
            cs_d[i] <= 16'h0000;
            us_d[i] <= 16'h0000;
         end
      end else if (sf_valid && !(sf_block_start && !sf_is_b && frame_r != 8'h00)) begin
         // A bits fill the high byte, B bits the low byte
         cs_d[frame_r[7:3]][{~sf_is_b, bit_pos(frame_r)}] <= sf_cbit;
         us_d[frame_r[7:3]][{~sf_is_b, bit_pos(frame_r)}] <= sf_ubit;
      end
   end

   // Whole-block copy D to E in a single edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < sprx_pkg::BUF_WORDS; i++) begin
            cs_e[i] <= 16'h0000;
            us_e[i] <= 16'h0000;
         end
      end else if (xfer_pend_r) begin
         for (int i = 0; i < sprx_pkg::BUF_WORDS; i++) begin
            cs_e[i] <= cs_d[i];
            us_e[i] <= us_d[i];
         end
      end
   end

   // Any bit differing between D and E
   always_comb begin
      changed = 1'b0;
      for (int i = 0; i < sprx_pkg::BUF_WORDS; i++) begin
         changed = changed | (cs_d[i] != cs_e[i]) | (us_d[i] != us_e[i]);
      end
   end

   // Change interrupt flag; set wins over read clear
   // Cleared only when the read reported it set
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_irq_r <= 1'b0;
      end else if (xfer_pend_r && changed) begin
         cs_irq_r <= 1'b1;
      end else if (rd_fire && idx == sprx_pkg::IDX_CS_IRQ && avs_readdata[0]) begin
         cs_irq_r <= 1'b0;
      end
   end

   assign status_change_irq = cs_irq_r & cs_irq_mask_r;

   // Selected subframe status bits in arrival order
   always_comb begin
      cs_sel = '0;
      for (int n = 0; n < sprx_pkg::BLK_FRAMES; n++) begin
         cs_sel[n] = cs_e[n / 8][{~buf_ctrl_r[sprx_pkg::F_CHSEL], bit_pos(8'(n))}];
      end
   end

   // Channel status decodes
   assign category           = cs_sel[15:8];
   assign studio_format_flag = cs_sel[0];
   assign copyright_flag     = ~cs_sel[0] & (~cs_sel[2] | (category == sprx_pkg::CAT_GENERAL));
   assign first_generation_flag = ~cs_sel[0] & (category != sprx_pkg::CAT_GENERAL) &
                                  (cs_sel[15] ^ gen_inverted(category));
   assign audio_flag         = nonpcm_sync_seen | cs_sel[1];
   assign emph_5015          = cs_sel[0] ? ({cs_sel[2], cs_sel[3], cs_sel[4]} == sprx_pkg::EMPH_PRO_5015)
                                         : ({cs_sel[3], cs_sel[4], cs_sel[5]} == sprx_pkg::EMPH_CONS_5015);
   assign word_len           = cs_sel[0] ? {cs_sel[18], cs_sel[19], cs_sel[20], cs_sel[21]}
                                         : {cs_sel[32], cs_sel[33], cs_sel[34], cs_sel[35]};

   // De-emphasis control to the filter path
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         deemph_enable <= 1'b0;
      end else begin
         deemph_enable <= emph_5015 & buf_ctrl_r[sprx_pkg::F_AUTODE];
      end
   end

   // Only line, eye, biphase, parity and validity errors touch samples
   assign sample_err = |(err_hit & sprx_pkg::SAMPLE_AFFECT);

   // Sample path with hold policy; full 24 bits pass otherwise
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_sample <= 24'h000000;
         out_valid  <= 1'b0;
         out_is_b   <= 1'b0;
         hold_a_r   <= 24'h000000;
         hold_b_r   <= 24'h000000;
      end else begin
         out_valid <= sf_valid;
         if (sf_valid) begin
            out_is_b <= sf_is_b;
            if (!sample_err || hold_sel == sprx_pkg::SPRX_HOLD_PASS) begin
               out_sample <= sf_sample;
               if (sf_is_b) begin
                  hold_b_r <= sf_sample;
               end else begin
                  hold_a_r <= sf_sample;
               end
            end else if (hold_sel == sprx_pkg::SPRX_HOLD_ZERO) begin
               out_sample <= 24'h000000;
            end else begin
               out_sample <= sf_is_b ? hold_b_r : hold_a_r;
            end
         end
      end
   end

   // Read mux, including the buffer window
   always_comb begin
      rd_val = 32'h00000000;
      case (idx)
         sprx_pkg::IDX_RX_ERR:     rd_val = {25'h0, err_r};
         sprx_pkg::IDX_ERR_MASK:   rd_val = {25'h0, err_mask_r};
         sprx_pkg::IDX_BUF_CTRL:   rd_val = {25'h0, buf_ctrl_r};
         sprx_pkg::IDX_CS_IRQ:     rd_val = {31'h0, cs_irq_r};
         sprx_pkg::IDX_CS_IRQ_MSK: rd_val = {31'h0, cs_irq_mask_r};
         sprx_pkg::IDX_DECODED: begin
            rd_val = {23'h0, emph_5015, word_len, audio_flag, first_generation_flag,
                      copyright_flag, studio_format_flag};
         end
         default: begin
            if (idx >= sprx_pkg::IDX_BUF_BASE &&
                idx < sprx_pkg::IDX_BUF_BASE + 8'(sprx_pkg::BUF_WORDS)) begin
               if (buf_ctrl_r[sprx_pkg::F_SRCSEL]) begin
                  rd_val = {16'h0, us_e[5'(idx - sprx_pkg::IDX_BUF_BASE)]};
               end else if (buf_ctrl_r[sprx_pkg::F_WIDTH]) begin
                  rd_val = {16'h0, cs_e[5'(idx - sprx_pkg::IDX_BUF_BASE)]};
               end else if (buf_ctrl_r[sprx_pkg::F_ONEB_SF]) begin
                  rd_val = {24'h0, cs_e[5'(idx - sprx_pkg::IDX_BUF_BASE)][7:0]};
               end else begin
                  rd_val = {24'h0, cs_e[5'(idx - sprx_pkg::IDX_BUF_BASE)][15:8]};
               end
            end
         end
      endcase
   end

   // Read data captured in the wait cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_r) begin
         avs_readdata <= rd_val;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_err_sticky;
      !(rd_fire && idx == sprx_pkg::IDX_RX_ERR) |=> ((err_r & $past(err_r)) == $past(err_r));
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

   property p_err_rec;
      (err_hit != 7'h00) |=> ((err_r & $past(err_hit)) == $past(err_hit));
   endproperty
   a_err_rec: assert property (p_err_rec) else $error("unmasked error missed");

   property p_no_irq;
      (err_r == 7'h00) && ((err_in & err_mask_r) == 7'h00) |=> !receiver_error_irq;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("irq without error");

   property p_zero;
      sf_valid && sample_err && hold_sel == sprx_pkg::SPRX_HOLD_ZERO |=> out_sample == 24'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("mute hold failed");

   property p_pass;
      sf_valid && !sample_err |=> out_valid && out_sample == $past(sf_sample);
   endproperty
   a_pass: assert property (p_pass) else $error("sample altered");

   property p_xfer;
      xfer_pend_r |=> (cs_e[0] == $past(cs_d[0])) && (cs_e[23] == $past(cs_d[23]));
   endproperty
   a_xfer: assert property (p_xfer) else $error("block copy wrong");

   property p_chg_irq;
      xfer_pend_r && changed && cs_irq_mask_r |=> status_change_irq;
   endproperty
   a_chg_irq: assert property (p_chg_irq) else $error("change irq missing");

   property p_audio;
      audio_flag == (nonpcm_sync_seen |
                     (buf_ctrl_r[sprx_pkg::F_CHSEL] ? cs_e[0][6] : cs_e[0][14]));
   endproperty
   a_audio: assert property (p_audio) else $error("audio flag wrong");

   property p_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late");

   property p_one_byte;
      rd_fire && idx >= sprx_pkg::IDX_BUF_BASE && idx < sprx_pkg::IDX_BUF_BASE + 8'h18 &&
      !buf_ctrl_r[sprx_pkg::F_SRCSEL] && !buf_ctrl_r[sprx_pkg::F_WIDTH] |->
      avs_readdata[31:8] == 24'h000000;
   endproperty
   a_one_byte: assert property (p_one_byte) else $error("one-byte read too wide");

   c_xfer: cover property (xfer_pend_r && changed);
   c_zero: cover property (sf_valid && sample_err && hold_sel == sprx_pkg::SPRX_HOLD_ZERO);
   c_err_read: cover property (rd_fire && idx == sprx_pkg::IDX_RX_ERR && err_r != 7'h00);
   c_user_read: cover property (rd_fire && buf_ctrl_r[sprx_pkg::F_SRCSEL]);
endmodule

/* File: sprx_src_model.sv */
/*
 Behavioural S/PDIF frame source driving the subframe stream of the block.
 Assumes its tasks are entered just after a rising core_clk edge.
*/
`timescale 1ns/1ps
module sprx_src_model (
   // Clock
   input  wire logic core_clk,
   // Subframe stream
   output logic        sf_valid,
   output logic        sf_is_b,
   output logic        sf_block_start,
   output logic [23:0] sf_sample,
   output logic        sf_cbit,
   output logic        sf_ubit,
   output logic        sf_vbit
);
   // Idle stream at time zero
   initial begin
      {sf_valid, sf_is_b, sf_block_start} = 3'h0;
      sf_sample = 24'h0;
      {sf_cbit, sf_ubit, sf_vbit} = 3'h0;
   end

   // One subframe strobe; afterwards data lines carry the inverse, not stale values
   task automatic send_sub(input logic b, input logic st, input logic [23:0] s,
                           input logic c, input logic v, input int gap);
      sf_valid       <= 1'b1;
      sf_is_b        <= b;
      sf_block_start <= st;
      sf_sample      <= s;
      {sf_cbit, sf_ubit, sf_vbit} <= {c, ~c, v}; // User bit is the inverse of the status bit
      @(posedge core_clk);
      sf_valid       <= 1'b0;
      sf_block_start <= 1'b0;
      sf_sample      <= ~s;
      {sf_cbit, sf_ubit, sf_vbit} <= {~c, c, ~v};
      repeat (gap) @(posedge core_clk);
   endtask

   // Whole block, A before B in every frame, frame 0 marked; bit n is vector bit 191-n
   task automatic send_block(input logic [191:0] ca, input logic [191:0] cb, input int gap);
      for (int n = 0; n < 192; n++) begin
         send_sub(1'b0, n == 0, 24'h100000 + 24'(n), ca[191-n], 1'b0, gap);
         send_sub(1'b1, 1'b0, 24'h200000 + 24'(n), cb[191-n], 1'b0, gap);
      end
   endtask
endmodule

/* File: sprx_status_buffer_tb.sv */
/*
 Self-checking bench for the receiver status block: error logging, hold,
 status decode and the D/E buffer. Assumes assertions live in the design.
*/
`timescale 1ns/1ps
module sprx_status_buffer_tb;
   logic        core_clk;
   logic        rst_b;
   logic [9:0]  avs_address;
   logic        avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata;
   logic        sf_valid, sf_is_b, sf_block_start, sf_cbit, sf_ubit, sf_vbit;
   logic [23:0] sf_sample, out_sample;
   logic [6:0]  errs;
   logic        nonpcm_sync_seen, out_valid, out_is_b, deemph_enable;
   logic        receiver_error_irq, status_change_irq;
   int          n_errors = 0;
   int          checked  = 0;

   // Design and stream source
   sprx_status_buffer i_dut (
      .core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .sf_valid, .sf_is_b, .sf_block_start,
      .sf_sample, .sf_cbit, .sf_ubit, .sf_vbit, .pll_unlock (errs[0]),
      .eye_margin_warning (errs[2]), .biphase_code_error (errs[3]),
      .odd_even_check_error (errs[4]), .subcode_q_checksum_error (errs[5]),
      .status_block_checksum_error (errs[6]), .nonpcm_sync_seen, .out_sample,
      .out_valid, .out_is_b, .deemph_enable, .receiver_error_irq, .status_change_irq
   );
   sprx_src_model i_src (
      .core_clk, .sf_valid, .sf_is_b, .sf_block_start, .sf_sample, .sf_cbit,
      .sf_ubit, .sf_vbit
   );

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Verdict and end of run
   task automatic stop_test();
      $display("Comparisons %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Mismatch report and the compare tasks
   task automatic fail(input logic [31:0] g, input logic [31:0] e);
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) fail(g, e);
   endtask
   task automatic chk_smp(input logic [23:0] g, input logic [23:0] e);
      checked++;
      if (g !== e) fail({8'h0, g}, {8'h0, e});
   endtask
   task automatic chk_bit(input logic g, input logic e);
      checked++;
      if (g !== e) fail({31'h0, g}, {31'h0, e});
   endtask

   // Avalon access: held until waitrequest is seen low at an edge, then released
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      int k;
      avs_address   <= {idx, 2'h0};
      avs_writedata <= wd;
      avs_read      <= ~wr;
      avs_write     <= wr;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      rd = avs_readdata;
      if (k >= 20) begin
         fail(32'h1, 32'h0);
         stop_test();
      end
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, i, d, x);
   endtask
   task automatic rd_chk(input logic [7:0] i, input logic [31:0] e,
                         input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] x;
      bus(1'b0, i, 32'h0, x);
      chk_reg(x & m, e);
   endtask

   // One subframe with error inputs raised alongside, output judged next cycle
   task automatic sub_chk(input logic b, input logic [23:0] s, input logic [6:0] ev,
                          input logic [23:0] e);
      errs <= ev;
      i_src.send_sub(b, 1'b0, s, 1'b0, 1'b0, 0);
      errs <= 7'h0;
      @(negedge core_clk);
      chk_bit(out_valid, 1'b1);
      chk_bit(out_is_b, b);
      chk_smp(out_sample, e);
      @(posedge core_clk);
   endtask

   // Reset values, unmapped place, mask width
   task automatic t_regs();
      rd_chk(sprx_pkg::IDX_ERR_MASK, 32'h0);
      rd_chk(sprx_pkg::IDX_BUF_CTRL, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      rd_chk(8'h10, 32'h0);
      wr(sprx_pkg::IDX_ERR_MASK, 32'hFFFFFFFF);
      rd_chk(sprx_pkg::IDX_ERR_MASK, 32'h7F);
      wr(sprx_pkg::IDX_ERR_MASK, 32'h0);
   endtask

   // Two equal blocks: change flag on the first only; buffer read in every mode
   task automatic t_block();
      logic [7:0]   a[24];
      logic [7:0]   b[24];
      logic [191:0] va, vb;
      logic [7:0]   ad;
      for (int k = 0; k < 24; k++) begin
         a[k] = (k == 0) ? 8'h60 : (k == 1) ? 8'h00 : 8'(k * 13);
         b[k] = (k == 0) ? 8'hA0 : ~a[k];
         va[191-8*k -: 8] = a[k];
         vb[191-8*k -: 8] = b[k];
      end
      wr(sprx_pkg::IDX_CS_IRQ_MSK, 32'h1);
      i_src.send_block(va, vb, 1);
      repeat (4) @(posedge core_clk);
      chk_bit(status_change_irq, 1'b1);
      rd_chk(sprx_pkg::IDX_CS_IRQ, 32'h1);
      rd_chk(sprx_pkg::IDX_CS_IRQ, 32'h0);
      for (int k = 0; k < 24; k++) begin
         ad = sprx_pkg::IDX_BUF_BASE + 8'(k);
         wr(sprx_pkg::IDX_BUF_CTRL, 32'h4);
         rd_chk(ad, {16'h0, a[k], b[k]});
         wr(sprx_pkg::IDX_BUF_CTRL, 32'h0);
         rd_chk(ad, {24'h0, a[k]});
         wr(sprx_pkg::IDX_BUF_CTRL, 32'h8);
         rd_chk(ad, {24'h0, b[k]});
         wr(sprx_pkg::IDX_BUF_CTRL, 32'h2);
         rd_chk(ad, {16'h0, ~a[k], ~b[k]});
      end
      wr(sprx_pkg::IDX_BUF_CTRL, 32'h40);
      rd_chk(sprx_pkg::IDX_DECODED, 32'h00A, 32'h10F);
      chk_bit(deemph_enable, 1'b0);
      wr(sprx_pkg::IDX_BUF_CTRL, 32'h41);
      rd_chk(sprx_pkg::IDX_DECODED, 32'h101, 32'h10F);
      chk_bit(deemph_enable, 1'b1);
      nonpcm_sync_seen <= 1'b1;
      @(posedge core_clk);
      rd_chk(sprx_pkg::IDX_DECODED, 32'h109, 32'h10F);
      nonpcm_sync_seen <= 1'b0;
      i_src.send_block(va, vb, 3);
      repeat (4) @(posedge core_clk);
      chk_bit(status_change_irq, 1'b0);
      rd_chk(sprx_pkg::IDX_CS_IRQ, 32'h0);
   endtask

   // Each condition masked, then unmasked; flag sticks until the read
   task automatic t_err();
      for (int i = 0; i < 7; i++) begin
         wr(sprx_pkg::IDX_ERR_MASK, 32'(i == 0 ? 0 : 7'h7F & ~(7'h1 << i)));
         if (i == 1) i_src.send_sub(1'b0, 1'b0, 24'h0, 1'b0, 1'b1, 1);
         else errs[i] <= 1'b1;
         @(posedge core_clk);
         errs <= 7'h0;
         repeat (3) @(posedge core_clk);
         chk_bit(receiver_error_irq, 1'b0);
         rd_chk(sprx_pkg::IDX_RX_ERR, 32'h0);
         wr(sprx_pkg::IDX_ERR_MASK, 32'h7F);
         if (i == 1) i_src.send_sub(1'b1, 1'b0, 24'h0, 1'b0, 1'b1, 1);
         else errs[i] <= 1'b1;
         @(posedge core_clk);
         errs <= 7'h0;
         repeat (3) @(posedge core_clk);
         chk_bit(receiver_error_irq, 1'b1);
         rd_chk(sprx_pkg::IDX_RX_ERR, 32'h1 << i);
         rd_chk(sprx_pkg::IDX_RX_ERR, 32'h0);
         chk_bit(receiver_error_irq, 1'b0);
      end
   endtask

   // Every hold policy against a parity error, then both checksum errors
   task automatic t_hold();
      logic [23:0] e;
      wr(sprx_pkg::IDX_ERR_MASK, 32'h7F);
      for (int p = 0; p < 4; p++) begin
         wr(sprx_pkg::IDX_BUF_CTRL, 32'(p) << 4);
         e = (p == 1) ? 24'h0 : (p == 3) ? 24'hC3C3C3 : 24'h5A5A5A;
         sub_chk(1'b0, 24'h5A5A5A, 7'h00, 24'h5A5A5A);
         sub_chk(1'b1, 24'hA5A5A5, 7'h00, 24'hA5A5A5);
         sub_chk(1'b0, 24'hC3C3C3, 7'h10, e);
         sub_chk(1'b1, 24'h3C3C3C, 7'h20, 24'h3C3C3C);
         sub_chk(1'b0, 24'hF0F0F0, 7'h40, 24'hF0F0F0);
         sub_chk(1'b1, 24'h0F0F0F, 7'h00, 24'h0F0F0F);
         rd_chk(sprx_pkg::IDX_RX_ERR, 32'h70);
      end
   endtask

   // Reset, then the scenarios in an order that keeps the frame count aligned
   initial begin
      rst_b = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = 44'h0;
      errs = 7'h0;
      nonpcm_sync_seen = 1'b0;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_block();
      t_err();
      t_hold();
      stop_test();
   end
endmodule
